// >>> bls_pkg.sv
package bls_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BTB_ENTRIES = 32;
   localparam int BTB_WAYS = 4;
   // the short variant has 8 stages, the long variant 10
   localparam int PIPE_DEPTH_SHORT = 8;
   localparam int PIPE_DEPTH_LONG = 10;
   localparam int BANK_W = 2;
   localparam int OFF_W = 8;
   localparam int DEPTH_FIELD_W = 8;
   localparam logic [ADDR_W-1:0] INSTR_STEP = 32'h0000_0001;
   localparam logic [DATA_W-1:0] COUNT_STEP = 32'h0000_0001;
   localparam logic [ADDR_W-1:0] RESET_PC_DEF = 32'h0000_0000;

   localparam logic [OFF_W-1:0] REG_CTRL = 8'h00;
   localparam logic [OFF_W-1:0] REG_STATUS = 8'h04;
   localparam logic [OFF_W-1:0] REG_CALL_RETURN_ADDRESS = 8'h08;
   localparam logic [OFF_W-1:0] REG_LOOP_COUNTER_ZERO = 8'h0C;
   localparam logic [OFF_W-1:0] REG_LOOP_COUNTER_ONE = 8'h10;
   localparam logic [OFF_W-1:0] REG_FETCH_PC = 8'h14;
   localparam logic [OFF_W-1:0] REG_BTB_HITS = 8'h18;
   localparam logic [OFF_W-1:0] REG_FLUSHES = 8'h1C;

   localparam int CTRL_BTB_EN_BIT = 0;
   localparam logic CTRL_BTB_EN_RST = 1'b1;
   localparam int ST_ZERO_EXPIRED_BIT = 0;
   localparam int ST_ONE_EXPIRED_BIT = 1;
   localparam int ST_BTB_EN_BIT = 2;
   localparam int ST_DEPTH_LSB = 8;

   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [2:0] {
      KIND_NONE = 3'b000,
      KIND_JUMP = 3'b001,
      KIND_CALL = 3'b010,
      KIND_RET = 3'b011,
      KIND_LOOP = 3'b100
   } bls_kind_t;

   typedef enum logic [1:0] {
      OPT_DEFAULT = 2'b00,
      OPT_PREDICT = 2'b01,
      OPT_NO_PREDICT = 2'b10,
      OPT_SPARE = 2'b11
   } bls_pred_t;

   typedef struct packed {
      logic valid;
      bls_kind_t kind;
      bls_pred_t opt;
      logic cond;
      logic cnt_sel;
      logic test_expired;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] target;
      logic [ADDR_W-1:0] next_fetch;
   } bls_branch_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] target;
   } bls_btb_wr_t;

   function automatic logic is_predicted(input bls_pred_t opt);
      return opt != OPT_NO_PREDICT;
   endfunction
endpackage

// >>> bls_btb.sv
`timescale 1ns/10ps
`default_nettype none
module bls_btb
   import bls_pkg::*;
#(
   parameter int ENTRIES = BTB_ENTRIES,
   parameter int WAYS = BTB_WAYS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic lk_en,
   input wire logic [ADDR_W-1:0] lk_addr,
   output logic lk_hit,
   output logic [ADDR_W-1:0] lk_target,
   input wire bls_btb_wr_t wr
);
   localparam int SETS = ENTRIES / WAYS;
   localparam int SET_W = $clog2(SETS);
   localparam int WAY_W = $clog2(WAYS);

   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] tag;
      logic [ADDR_W-1:0] target;
   } bls_entry_t;

   typedef struct packed {
      bls_entry_t [ENTRIES-1:0] ent;
      logic [SETS-1:0][WAY_W-1:0] victim;
   } bls_btb_state_t;

   bls_btb_state_t q;
   bls_btb_state_t d;
   logic [WAYS-1:0] lk_hits;
   logic [WAYS-1:0] wr_hits;
   logic [SET_W-1:0] lk_set;
   logic [SET_W-1:0] wr_set;
   logic [WAY_W-1:0] wr_way;
   logic wr_found;

   function automatic int unsigned slot(input logic [SET_W-1:0] set, input int unsigned way);
      return int'(set) * WAYS + way;
   endfunction

   // tag is the whole address, so a hit never aliases another branch
   always_comb begin
      d = q;
      lk_set = lk_addr[SET_W-1:0];
      wr_set = wr.addr[SET_W-1:0];
      lk_hit = 1'b0;
      lk_target = '0;
      wr_found = 1'b0;
      wr_way = q.victim[wr_set];
      for (int w = 0; w < WAYS; w++) begin
         lk_hits[w] = q.ent[slot(lk_set, w)].valid && (q.ent[slot(lk_set, w)].tag == lk_addr);
         wr_hits[w] = q.ent[slot(wr_set, w)].valid && (q.ent[slot(wr_set, w)].tag == wr.addr);
         if (lk_en && lk_hits[w]) begin
            lk_hit = 1'b1;
            lk_target = q.ent[slot(lk_set, w)].target;
         end
         if (wr_hits[w]) begin
            wr_found = 1'b1;
            wr_way = WAY_W'(w);
         end
      end
      if (wr.en) begin
         d.ent[slot(wr_set, wr_way)] = '{valid: 1'b1, tag: wr.addr, target: wr.target};
         if (!wr_found) begin
            d.victim[wr_set] = WAY_W'(q.victim[wr_set] + 1'b1);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_single_way;
      $onehot0(lk_hits);
   endproperty
   a_single_way: assert property (p_single_way)
      else $error("btb holds one branch in two ways");

   property p_learned;
      wr.en ##1 (lk_en && (lk_addr == $past(wr.addr))) |-> lk_hit && (lk_target == $past(wr.target));
   endproperty
   a_learned: assert property (p_learned)
      else $error("recorded branch target not returned on next lookup");
endmodule
`default_nettype wire

// >>> bls_sequencer.sv
// What this block does
// - interlocked pipeline stalls fetch; 8 or 10 stages
// - target buffer is 32 entries, 4-way set-associative
// - taken predicted branch records target, redirects fetch later
// - buffer used only when enabled and branch predicted
// - no option means predicted; explicit option overrides
// - no-predict branches never write the buffer
// - call overwrites the single return address register
// - return jumps to the stored return address
// - no delayed branch; wrong-path instructions are flushed
// - two loop counters, expired and not-expired conditions
// - loop closes by jumping back while not expired
// - fetch runs alongside two data accesses, separate banks
`timescale 1ns/10ps
`default_nettype none
module bls_sequencer
   import bls_pkg::*;
#(
   parameter int PIPE_DEPTH = PIPE_DEPTH_SHORT,
   parameter logic [ADDR_W-1:0] RESET_PC = RESET_PC_DEF
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [ADDR_W-1:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [DATA_W-1:0] HWDATA,
   input wire logic HREADY,
   output logic [DATA_W-1:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [ADDR_W-1:0] FETCH_ADDR,
   output logic FETCH_REQ,
   input wire logic HAZARD,
   input wire logic DATA0_REQ,
   input wire logic [ADDR_W-1:0] DATA0_ADDR,
   input wire logic DATA1_REQ,
   input wire logic [ADDR_W-1:0] DATA1_ADDR,
   input wire bls_branch_t EX_BRANCH,
   output logic STALL,
   output logic FLUSH,
   output logic COUNTER_ZERO_EXPIRED,
   output logic COUNTER_ZERO_NOT_EXPIRED,
   output logic COUNTER_ONE_EXPIRED,
   output logic COUNTER_ONE_NOT_EXPIRED
);
   typedef struct packed {
      logic [ADDR_W-1:0] fetch_pc;
      logic btb_en;
      logic [ADDR_W-1:0] call_return_address;
      logic [DATA_W-1:0] loop_counter_zero;
      logic [DATA_W-1:0] loop_counter_one;
      logic [DATA_W-1:0] btb_hits;
      logic [DATA_W-1:0] flushes;
      logic dp_valid;
      logic dp_write;
      logic [OFF_W-1:0] dp_off;
      logic [DATA_W-1:0] rdata;
   } bls_seq_state_t;

   bls_seq_state_t q;
   bls_seq_state_t d;
   bls_branch_t br;
   bls_btb_wr_t btb_wr;
   logic lk_hit;
   logic [ADDR_W-1:0] lk_target;
   logic hold;
   logic bank_clash;
   logic taken_w;
   logic [ADDR_W-1:0] tgt_w;
   logic [ADDR_W-1:0] actual_next;
   logic mispredict;
   logic [DATA_W-1:0] cnt_cur;
   logic [DATA_W-1:0] cnt_next;
   logic sw_we;
   logic sw_call_we;
   logic sw_zero_we;
   logic sw_one_we;
   logic addr_take;

   function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1 -: BANK_W];
   endfunction

   function automatic logic [DATA_W-1:0] reg_read(input bls_seq_state_t s, input logic [OFF_W-1:0] off);
      logic [DATA_W-1:0] r;
      r = '0;
      case (off)
         REG_CTRL: begin
            r[CTRL_BTB_EN_BIT] = s.btb_en;
         end
         REG_STATUS: begin
            r[ST_ZERO_EXPIRED_BIT] = (s.loop_counter_zero == '0);
            r[ST_ONE_EXPIRED_BIT] = (s.loop_counter_one == '0);
            r[ST_BTB_EN_BIT] = s.btb_en;
            r[ST_DEPTH_LSB +: DEPTH_FIELD_W] = DEPTH_FIELD_W'(PIPE_DEPTH);
         end
         REG_CALL_RETURN_ADDRESS: begin
            r = s.call_return_address;
         end
         REG_LOOP_COUNTER_ZERO: begin
            r = s.loop_counter_zero;
         end
         REG_LOOP_COUNTER_ONE: begin
            r = s.loop_counter_one;
         end
         REG_FETCH_PC: begin
            r = s.fetch_pc;
         end
         REG_BTB_HITS: begin
            r = s.btb_hits;
         end
         REG_FLUSHES: begin
            r = s.flushes;
         end
         default: begin
            r = '0;
         end
      endcase
      return r;
   endfunction

   bls_btb #(
      .ENTRIES(BTB_ENTRIES),
      .WAYS(BTB_WAYS)
   ) u_branch_target_buffer (
      .clk(CLK),
      .rst(RST),
      .lk_en(q.btb_en),
      .lk_addr(q.fetch_pc),
      .lk_hit(lk_hit),
      .lk_target(lk_target),
      .wr(btb_wr)
   );

   always_comb begin
      d = q;
      br = EX_BRANCH;

      // instruction fetch has its own bus; it waits on a hazard or when a data access hits its bank
      bank_clash = (DATA0_REQ && (bank_of(DATA0_ADDR) == bank_of(q.fetch_pc)))
         || (DATA1_REQ && (bank_of(DATA1_ADDR) == bank_of(q.fetch_pc)));
      hold = HAZARD || bank_clash;

      cnt_cur = br.cnt_sel ? q.loop_counter_one : q.loop_counter_zero;
      cnt_next = cnt_cur - COUNT_STEP;
      taken_w = 1'b0;
      tgt_w = br.target;
      case (br.kind)
         KIND_JUMP: begin
            taken_w = br.cond;
         end
         KIND_CALL: begin
            taken_w = br.cond;
         end
         KIND_RET: begin
            taken_w = br.cond;
            tgt_w = q.call_return_address;
         end
         KIND_LOOP: begin
            taken_w = br.test_expired ? (cnt_next == '0) : (cnt_next != '0);
         end
         default: begin
            taken_w = 1'b0;
         end
      endcase

      actual_next = taken_w ? tgt_w : br.pc + INSTR_STEP;
      // anything fetched behind a branch that does not match the real path is killed
      mispredict = br.valid && (actual_next != br.next_fetch);

      btb_wr.en = br.valid && q.btb_en && is_predicted(br.opt)
         && (br.kind != KIND_NONE) && taken_w;
      btb_wr.addr = br.pc;
      btb_wr.target = tgt_w;

      if (br.valid && (br.kind == KIND_CALL) && taken_w) begin
         d.call_return_address = br.pc + INSTR_STEP;
      end
      if (br.valid && (br.kind == KIND_LOOP)) begin
         if (br.cnt_sel) begin
            d.loop_counter_one = cnt_next;
         end else begin
            d.loop_counter_zero = cnt_next;
         end
      end

      if (mispredict) begin
         d.fetch_pc = actual_next;
         d.flushes = q.flushes + COUNT_STEP;
      end else if (!hold) begin
         d.fetch_pc = lk_hit ? lk_target : q.fetch_pc + INSTR_STEP;
         if (lk_hit) begin
            d.btb_hits = q.btb_hits + COUNT_STEP;
         end
      end

      // software writes land after the hardware updates, so a write wins a same-cycle clash
      sw_we = q.dp_valid && q.dp_write;
      sw_call_we = sw_we && (q.dp_off == REG_CALL_RETURN_ADDRESS);
      sw_zero_we = sw_we && (q.dp_off == REG_LOOP_COUNTER_ZERO);
      sw_one_we = sw_we && (q.dp_off == REG_LOOP_COUNTER_ONE);
      if (sw_we && (q.dp_off == REG_CTRL)) begin
         d.btb_en = HWDATA[CTRL_BTB_EN_BIT];
      end
      if (sw_call_we) begin
         d.call_return_address = HWDATA;
      end
      if (sw_zero_we) begin
         d.loop_counter_zero = HWDATA;
      end
      if (sw_one_we) begin
         d.loop_counter_one = HWDATA;
      end

      addr_take = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;
      d.dp_valid = addr_take;
      d.dp_write = HWRITE;
      d.dp_off = HADDR[OFF_W-1:0];
      // read data is taken from the next state, so a read right behind a write sees it
      if (addr_take && !HWRITE) begin
         d.rdata = reg_read(d, HADDR[OFF_W-1:0]);
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
         q.fetch_pc <= RESET_PC;
         q.btb_en <= CTRL_BTB_EN_RST;
      end else begin
         q <= d;
      end
   end

   assign HRDATA = q.rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = HRESP_OKAY;
   assign FETCH_ADDR = q.fetch_pc;
   assign FETCH_REQ = !hold;
   assign STALL = hold;
   assign FLUSH = mispredict;
   assign COUNTER_ZERO_EXPIRED = (q.loop_counter_zero == '0);
   assign COUNTER_ZERO_NOT_EXPIRED = (q.loop_counter_zero != '0);
   assign COUNTER_ONE_EXPIRED = (q.loop_counter_one == '0);
   assign COUNTER_ONE_NOT_EXPIRED = (q.loop_counter_one != '0);

   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   property p_interlock;
      HAZARD && !FLUSH |-> STALL && !FETCH_REQ ##1 $stable(FETCH_ADDR);
   endproperty
   a_interlock: assert property (p_interlock)
      else $error("fetch moved during a hazard stall");

   property p_gated;
      !q.btb_en |-> !btb_wr.en && !lk_hit;
   endproperty
   a_gated: assert property (p_gated)
      else $error("target buffer used while disabled");

   property p_default_predicted;
      br.valid && (br.kind == KIND_JUMP) && (br.opt == OPT_DEFAULT) && br.cond && q.btb_en |-> btb_wr.en;
   endproperty
   a_default_predicted: assert property (p_default_predicted)
      else $error("branch without option was not treated as predicted");

   property p_no_predict;
      br.valid && (br.opt == OPT_NO_PREDICT) |-> !btb_wr.en;
   endproperty
   a_no_predict: assert property (p_no_predict)
      else $error("no-predict branch wrote the target buffer");

   property p_call_record;
      br.valid && (br.kind == KIND_CALL) && br.cond && !sw_call_we
         |=> q.call_return_address == $past(br.pc) + INSTR_STEP;
   endproperty
   a_call_record: assert property (p_call_record)
      else $error("call did not store its return address");

   property p_return;
      br.valid && (br.kind == KIND_RET) && br.cond && (br.next_fetch != q.call_return_address)
         |-> FLUSH ##1 (FETCH_ADDR == $past(q.call_return_address));
   endproperty
   a_return: assert property (p_return)
      else $error("return did not go to the stored address");

   property p_no_delay_slot;
      br.valid && taken_w && (br.next_fetch != tgt_w) |-> FLUSH ##1 (FETCH_ADDR == $past(tgt_w));
   endproperty
   a_no_delay_slot: assert property (p_no_delay_slot)
      else $error("taken branch let wrong-path instructions through");

   property p_expired_flag;
      br.valid && (br.kind == KIND_LOOP) && br.cnt_sel && (q.loop_counter_one == COUNT_STEP) && !sw_one_we
         |=> COUNTER_ONE_EXPIRED && !COUNTER_ONE_NOT_EXPIRED;
   endproperty
   a_expired_flag: assert property (p_expired_flag)
      else $error("counter one did not report expired");

   property p_loop_close;
      br.valid && (br.kind == KIND_LOOP) && !br.test_expired && (cnt_next != '0) && (br.next_fetch != br.target)
         |-> FLUSH ##1 (FETCH_ADDR == $past(br.target));
   endproperty
   a_loop_close: assert property (p_loop_close)
      else $error("loop did not return to its start");

   property p_parallel_fetch;
      !HAZARD && (bank_of(DATA0_ADDR) != bank_of(FETCH_ADDR)) && (bank_of(DATA1_ADDR) != bank_of(FETCH_ADDR))
         |-> FETCH_REQ;
   endproperty
   a_parallel_fetch: assert property (p_parallel_fetch)
      else $error("fetch blocked by data accesses in other banks");

   property p_loop_decrement;
      br.valid && (br.kind == KIND_LOOP) && !br.cnt_sel && !sw_zero_we
         |=> q.loop_counter_zero == $past(q.loop_counter_zero) - COUNT_STEP;
   endproperty
   a_loop_decrement: assert property (p_loop_decrement)
      else $error("loop test did not decrement counter zero");
endmodule
`default_nettype wire

// >>> bls_imem_model.sv
`timescale 1ns/10ps
`default_nettype none
module bls_imem_model
   import bls_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic fetch_req,
   input wire logic d0_on,
   input wire logic [1:0] d0_bank,
   input wire logic d1_on,
   input wire logic [1:0] d1_bank,
   output logic data0_req,
   output logic [ADDR_W-1:0] data0_addr,
   output logic data1_req,
   output logic [ADDR_W-1:0] data1_addr,
   output logic [DATA_W-1:0] instr
);
   logic [ADDR_W-1:0] a0_q;
   logic [ADDR_W-1:0] a1_q;
   // idle address lines show the inverse of their value one cycle earlier, so a stale address reappears every second cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         a0_q <= 32'h0000_0000;
         a1_q <= 32'h0000_0000;
         instr <= 32'h0000_0000;
      end else begin
         a0_q <= data0_addr;
         a1_q <= data1_addr;
         instr <= fetch_req ? ~fetch_addr : ~instr; // own bank serves fetch beside data
      end
   end
   assign data0_req = d0_on;
   assign data1_req = d1_on;
   assign data0_addr = d0_on ? {d0_bank, 30'h0000_0040} : ~a0_q;
   assign data1_addr = d1_on ? {d1_bank, 30'h0000_0080} : ~a1_q;
endmodule
`default_nettype wire

// >>> bls_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bls_sequencer_tb
   import bls_pkg::*;
;
   logic clk, rst, hsel, hwrite, hreadyout, hresp, fetch_req, hazard, stall, flush;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [ADDR_W-1:0] haddr, fetch_addr, d0_addr, d1_addr, a;
   logic [DATA_W-1:0] hwdata, hrdata, h0, h1;
   logic d0_on, d1_on, d0_req, d1_req, ze, zne, oe, one;
   logic [1:0] d0_bank, d1_bank;
   bls_branch_t ex;
   int num_errors, checks, nfl, i;

   bls_sequencer bls_sequencer_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .FETCH_ADDR(fetch_addr), .FETCH_REQ(fetch_req),
      .HAZARD(hazard), .DATA0_REQ(d0_req), .DATA0_ADDR(d0_addr), .DATA1_REQ(d1_req),
      .DATA1_ADDR(d1_addr), .EX_BRANCH(ex), .STALL(stall), .FLUSH(flush),
      .COUNTER_ZERO_EXPIRED(ze), .COUNTER_ZERO_NOT_EXPIRED(zne), .COUNTER_ONE_EXPIRED(oe),
      .COUNTER_ONE_NOT_EXPIRED(one));

   bls_imem_model bls_imem_model_inst (.clk(clk), .rst(rst), .fetch_addr(fetch_addr),
      .fetch_req(fetch_req), .d0_on(d0_on), .d0_bank(d0_bank), .d1_on(d1_on), .d1_bank(d1_bank),
      .data0_req(d0_req), .data0_addr(d0_addr), .data1_req(d1_req), .data1_addr(d1_addr), .instr());

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   // bounded wait for hready at a rising edge
   task automatic bus_wait;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) begin
         num_errors++;
         $display("[FAIL] %0t: bus wait timed out", $time);
         end_of_test();
      end
   endtask

   task automatic ahb(input logic wr, input logic [7:0] off, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, off};
      bus_wait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      bus_wait();
      rd = hrdata;
      chk1(hresp, HRESP_OKAY);
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      logic [31:0] x;
      ahb(1'b1, off, d, x);
   endtask

   task automatic rdc(input logic [7:0] off, input logic [31:0] exp);
      logic [31:0] x;
      ahb(1'b0, off, 32'h0000_0000, x);
      chk32(x, exp);
   endtask

   task automatic rdv(input logic [7:0] off, output logic [31:0] v);
      ahb(1'b0, off, 32'h0000_0000, v);
   endtask

   // one resolving instruction; fl is the expected flush, nxt the fetch address after it
   task automatic br(input bls_kind_t k, input bls_pred_t o, input logic sel, input logic te,
         input logic [31:0] pc, input logic [31:0] tg, input logic fl, input logic [31:0] nxt);
      @(posedge clk);
      ex <= '{valid: 1'b1, kind: k, opt: o, cond: 1'b1, cnt_sel: sel, test_expired: te,
         pc: pc, target: tg, next_fetch: pc + 32'h0000_0001};
      #1;
      chk1(flush, fl);
      if (fl) begin
         nfl++;
      end
      @(posedge clk);
      ex.valid <= 1'b0;
      #1;
      if (fl) begin
         chk32(fetch_addr, nxt);
      end
   endtask

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      hazard = 1'b0;
      d0_on = 1'b0;
      d1_on = 1'b0;
      d0_bank = 2'h0;
      d1_bank = 2'h0;
      ex = '0;
      num_errors = 0;
      checks = 0;
      nfl = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(REG_CTRL, 32'h0000_0001);
      rdc(REG_STATUS, 32'h0000_0807);
      rdc(REG_CALL_RETURN_ADDRESS, 32'h0000_0000);
      wr(REG_STATUS, 32'hFFFF_FFFF);
      rdc(REG_STATUS, 32'h0000_0807);
      wr(8'h20, 32'h1234_5678);
      rdc(8'h20, 32'h0000_0000);
      // interlock holds the fetch address
      @(posedge clk);
      hazard <= 1'b1;
      #1;
      chk1(stall, 1'b1);
      chk1(fetch_req, 1'b0);
      a = fetch_addr;
      @(posedge clk);
      #1;
      chk32(fetch_addr, a);
      @(posedge clk);
      hazard <= 1'b0;
      d0_on <= 1'b1;
      d0_bank <= 2'h1;
      d1_on <= 1'b1;
      d1_bank <= 2'h2;
      #1;
      chk1(stall, 1'b0);
      chk1(fetch_req, 1'b1);
      @(posedge clk);
      d0_bank <= 2'h0;
      #1;
      chk1(stall, 1'b1);
      @(posedge clk);
      d0_on <= 1'b0;
      d1_on <= 1'b0;
      // target buffer: default, explicit predict, no-predict, disabled
      br(KIND_JUMP, OPT_DEFAULT, 1'b0, 1'b0, 32'h30, 32'h50, 1'b1, 32'h50);
      br(KIND_JUMP, OPT_NO_PREDICT, 1'b0, 1'b0, 32'h60, 32'h30, 1'b1, 32'h30);
      @(posedge clk);
      #1;
      chk32(fetch_addr, 32'h50);
      br(KIND_JUMP, OPT_NO_PREDICT, 1'b0, 1'b0, 32'h70, 32'h90, 1'b1, 32'h90);
      br(KIND_JUMP, OPT_NO_PREDICT, 1'b0, 1'b0, 32'h64, 32'h70, 1'b1, 32'h70);
      @(posedge clk);
      #1;
      chk32(fetch_addr, 32'h71);
      wr(REG_CTRL, 32'h0000_0000);
      rdc(REG_STATUS, 32'h0000_0803);
      br(KIND_JUMP, OPT_DEFAULT, 1'b0, 1'b0, 32'h80, 32'hA0, 1'b1, 32'hA0);
      wr(REG_CTRL, 32'h0000_0001);
      br(KIND_JUMP, OPT_NO_PREDICT, 1'b0, 1'b0, 32'h68, 32'h80, 1'b1, 32'h80);
      @(posedge clk);
      #1;
      chk32(fetch_addr, 32'h81);
      br(KIND_JUMP, OPT_PREDICT, 1'b0, 1'b0, 32'h98, 32'hC0, 1'b1, 32'hC0);
      br(KIND_JUMP, OPT_NO_PREDICT, 1'b0, 1'b0, 32'h6C, 32'h98, 1'b1, 32'h98);
      @(posedge clk);
      #1;
      chk32(fetch_addr, 32'hC0);
      // call and return through the single return register
      br(KIND_CALL, OPT_DEFAULT, 1'b0, 1'b0, 32'h20, 32'h40, 1'b1, 32'h40);
      rdc(REG_CALL_RETURN_ADDRESS, 32'h21);
      br(KIND_CALL, OPT_DEFAULT, 1'b0, 1'b0, 32'h44, 32'h180, 1'b1, 32'h180);
      rdc(REG_CALL_RETURN_ADDRESS, 32'h45);
      br(KIND_RET, OPT_DEFAULT, 1'b0, 1'b0, 32'h184, 32'h0, 1'b1, 32'h45);
      // counter zero closes a loop while not expired
      wr(REG_LOOP_COUNTER_ZERO, 32'h0000_0003);
      for (i = 2; i >= 0; i--) begin
         br(KIND_LOOP, OPT_DEFAULT, 1'b0, 1'b0, 32'h10, 32'h8, i != 0, 32'h8);
         chk1(zne, i != 0);
         chk1(ze, i == 0);
      end
      rdc(REG_LOOP_COUNTER_ZERO, 32'h0000_0000);
      // counter one with the expired form of the test
      wr(REG_LOOP_COUNTER_ONE, 32'h0000_0002);
      br(KIND_LOOP, OPT_DEFAULT, 1'b1, 1'b1, 32'h100, 32'h200, 1'b0, 32'h0);
      chk1(one, 1'b1);
      chk1(oe, 1'b0);
      br(KIND_LOOP, OPT_DEFAULT, 1'b1, 1'b1, 32'h100, 32'h200, 1'b1, 32'h200);
      chk1(oe, 1'b1);
      // a branch onto itself: the recorded target is hit on every later fetch
      br(KIND_JUMP, OPT_PREDICT, 1'b0, 1'b0, 32'h300, 32'h300, 1'b1, 32'h300);
      rdc(REG_FETCH_PC, 32'h0000_0300);
      // address phases of back to back reads are three edges apart, one hit per edge
      rdv(REG_BTB_HITS, h0);
      rdv(REG_BTB_HITS, h1);
      chk32(h1 - h0, 32'h0000_0003);
      rdc(REG_STATUS, 32'h0000_0807);
      rdc(REG_FLUSHES, nfl);
      end_of_test();
   end
endmodule
`default_nettype wire
